/* voltage_target_ramp_sequencer.sv */
// Voltage target ramp sequencer: command decode, code stepping, power state
module voltage_target_ramp_sequencer
  import vtrs_pkg::*;
#(
  parameter int RAMP_DIV_P = vtrs_pkg::RAMP_DIV,
  parameter int MASK_CYC_P = vtrs_pkg::MASK_CYC
) (
  // Clock and reset
  input  wire logic                   mclk_in,
  input  wire logic                   rst_in,
  // Device enable and start-up target
  input  wire logic                   enable_in,
  input  wire logic [7:0]             boot_code_in,
  // Commands from the serial voltage control bus
  input  wire logic                   cmd_valid_in,
  input  wire vtrs_pkg::cmd_t         cmd_code_in,
  input  wire logic [7:0]             cmd_addr_in,
  input  wire logic [7:0]             cmd_data_in,
  output logic                        cmd_ack_out,
  output logic                        cmd_reject_out,
  output logic [7:0]                  rsp_data_out,
  // Output settling feedback
  input  wire logic                   settled_flag_in,
  // Converter and phase control
  output logic [7:0]                  voltage_code_out,
  output logic                        ramp_active_out,
  output logic                        ready_mask_out,
  output logic [1:0]                  power_state_out,
  output logic                        all_phases_out
);
  import vtrs_pkg::*;

  if (RAMP_DIV_P < 2 || MASK_CYC_P < 1) begin : g_param_check
    $error("RAMP_DIV_P must be at least 2 and MASK_CYC_P at least 1");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  seq_state_t  state;
  logic [7:0]  code;
  logic [7:0]  target;
  logic [7:0]  offset;
  logic [7:0]  slow_rate;
  logic [7:0]  slow_cnt;
  logic        slow_mode;
  logic [1:0]  ps;
  logic        ps_pending;
  logic [1:0]  ps_pending_val;
  logic        enable_q;
  logic        settled_q;
  logic [4:0]  ra_cnt;
  logic        tick;
  logic        mask_q;

  // Target plus offset, clamped at the top code
  function automatic logic [7:0] dest_of(input logic [7:0] t, input logic [7:0] o);
    logic [8:0] sum;
    sum = {1'b0, t} + {1'b0, o};
    return sum[8] ? CODE_MAX : sum[7:0];
  endfunction

  logic [7:0] dest;
  logic       at_dest;
  logic       near_dest;
  logic       busy;
  logic       start_up;
  logic       settle_rise;
  logic       slow_hit;
  logic       step_now;
  logic       offset_ovf;
  logic       cmd_ok;

  assign dest        = dest_of(target, offset);
  assign at_dest     = (code == dest);
  assign near_dest   = at_dest || (code + 8'h01 == dest) || (dest + 8'h01 == code);
  assign busy        = (state == ST_RAMP);
  assign start_up    = enable_in && !enable_q;
  assign settle_rise = settled_flag_in && !settled_q;
  assign slow_hit    = (slow_cnt + 8'h01 >= slow_rate);
  assign offset_ovf  = ({1'b0, target} + {1'b0, cmd_data_in}) > {1'b0, CODE_MAX};

  // Step decision: fast per tick, slow per rate ticks, decay per settle
  always_comb begin
    step_now = 1'b0;
    if (enable_in && !at_dest) begin
      if (state == ST_RAMP) begin
        step_now = tick && (!slow_mode || slow_hit);
      end else if (state == ST_DECAY) begin
        step_now = settle_rise;
      end
    end
  end

  // Command acceptance
  always_comb begin
    cmd_ok = 1'b0;
    if (cmd_valid_in && enable_in && !busy && !start_up) begin
      unique case (cmd_code_in)
        CMD_SET_TARGET_FAST,
        CMD_SET_TARGET_SLOW,
        CMD_SET_TARGET_DECAY,
        CMD_SET_POWER_STATE,
        CMD_GET_REG: cmd_ok = 1'b1;
        CMD_SET_REG: cmd_ok = (cmd_addr_in == REG_SLOW_RATE) ||
                              (cmd_addr_in == REG_OFFSET && !offset_ovf);
        default: cmd_ok = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sub-blocks
  ramp_tick_gen #(.DIV(RAMP_DIV_P)) u_tick (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .run_in   (busy),
    .tick_out (tick)
  );

  ready_mask_timer #(.CYC(MASK_CYC_P)) u_mask (
    .mclk_in    (mclk_in),
    .rst_in     (rst_in),
    .stop_in    (!enable_in),
    .restart_in (step_now),
    .mask_out   (mask_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Edge memories
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      enable_q  <= 1'b0;
      settled_q <= 1'b0;
    end else begin
      enable_q  <= enable_in;
      settled_q <= settled_flag_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state, target, offset, power state
  always_ff @(posedge mclk_in) begin
    if (rst_in || !enable_in) begin
      state          <= ST_IDLE;
      target         <= CODE_RST;
      offset         <= OFFSET_RST;
      slow_mode      <= 1'b0;
      ps             <= FULL_POWER_STATE;
      ps_pending     <= 1'b0;
      ps_pending_val <= FULL_POWER_STATE;
    end else if (start_up) begin
      state     <= ST_RAMP;
      target    <= boot_code_in;
      slow_mode <= 1'b1;
    end else if (cmd_ok) begin
      unique case (cmd_code_in)
        CMD_SET_TARGET_FAST, CMD_SET_TARGET_SLOW: begin
          state      <= ST_RAMP;
          target     <= cmd_data_in;
          slow_mode  <= (cmd_code_in == CMD_SET_TARGET_SLOW);
          ps         <= FULL_POWER_STATE;
          ps_pending <= 1'b0;
        end
        CMD_SET_TARGET_DECAY: begin
          state  <= ST_DECAY;
          target <= cmd_data_in;
          ps     <= (ps == DEEP_PS) ? DEEP_PS : DECAY_PS;
        end
        CMD_SET_POWER_STATE: begin
          if (state == ST_DECAY) begin
            ps_pending     <= 1'b1;
            ps_pending_val <= cmd_data_in[1:0];
          end else begin
            ps <= cmd_data_in[1:0];
          end
        end
        CMD_SET_REG: begin
          if (cmd_addr_in == REG_OFFSET) begin
            offset    <= cmd_data_in;
            state     <= ST_RAMP;
            slow_mode <= 1'b1;
            ps        <= FULL_POWER_STATE;
          end
        end
        default: begin
        end
      endcase
    end else if (state != ST_IDLE && at_dest) begin
      state <= ST_IDLE;
      if (state == ST_DECAY && ps_pending) begin
        ps         <= ps_pending_val;
        ps_pending <= 1'b0;
      end
    end
  end

  // Slow rate register
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      slow_rate <= SLOW_RATE_RST;
    end else if (cmd_ok && cmd_code_in == CMD_SET_REG && cmd_addr_in == REG_SLOW_RATE) begin
      slow_rate <= cmd_data_in;
    end
  end

  // Slow rate tick counter
  always_ff @(posedge mclk_in) begin
    if (rst_in || !busy) begin
      slow_cnt <= 8'h00;
    end else if (tick) begin
      slow_cnt <= slow_hit ? 8'h00 : slow_cnt + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Voltage code stepping
  always_ff @(posedge mclk_in) begin
    if (rst_in || !enable_in) begin
      code <= CODE_RST;
    end else if (step_now) begin
      code <= (dest > code) ? code + 8'h01 : code - 8'h01;
    end
  end

  // Ramp active indication with least hold time
  always_ff @(posedge mclk_in) begin
    if (rst_in || !enable_in) begin
      ramp_active_out <= 1'b0;
      ra_cnt          <= 5'h00;
    end else if (start_up || (cmd_ok && cmd_code_in <= CMD_SET_TARGET_DECAY) ||
                 (cmd_ok && cmd_code_in == CMD_SET_REG && cmd_addr_in == REG_OFFSET)) begin
      ramp_active_out <= 1'b1;
      ra_cnt          <= 5'h01;
    end else if (ramp_active_out) begin
      if (ra_cnt < 5'(RAMP_MIN_CYC)) begin
        ra_cnt <= ra_cnt + 5'h01;
      end else if (near_dest) begin
        ramp_active_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cmd_ack_out      <= 1'b0;
      cmd_reject_out   <= 1'b0;
      rsp_data_out     <= 8'h00;
      voltage_code_out <= CODE_RST;
      ready_mask_out   <= 1'b0;
      power_state_out  <= FULL_POWER_STATE;
      all_phases_out   <= 1'b1;
    end else begin
      cmd_ack_out      <= cmd_valid_in && cmd_ok;
      cmd_reject_out   <= cmd_valid_in && !cmd_ok;
      if (cmd_ok && cmd_code_in == CMD_GET_REG) begin
        rsp_data_out <= (cmd_addr_in == REG_SLOW_RATE) ? slow_rate :
                        (cmd_addr_in == REG_OFFSET) ? offset : 8'h00;
      end
      voltage_code_out <= code;
      ready_mask_out   <= mask_q;
      power_state_out  <= ps;
      all_phases_out   <= (ps == FULL_POWER_STATE) || busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  sequence s_offset_cmd;
    cmd_valid_in && enable_in && !busy && !start_up && cmd_code_in == CMD_SET_REG &&
      cmd_addr_in == REG_OFFSET;
  endsequence

  a_code_single_step: assert property (
    enable_in && $past(enable_in) |-> (code == $past(code)) ||
      (code == $past(code) + 8'h01) || (code == $past(code) - 8'h01))
    else $error("code moved more than one step");
  a_fast_tick_step: assert property (
    busy && !slow_mode && code != $past(code) && $past(enable_in) |-> $past(tick))
    else $error("fast ramp stepped without ramp tick");
  a_offset_overflow: assert property (
    s_offset_cmd ##0 offset_ovf |=> cmd_reject_out && $stable(offset))
    else $error("overflowing offset not rejected");
  a_offset_accept: assert property (
    s_offset_cmd ##0 !offset_ovf |=> offset == $past(cmd_data_in) && busy && slow_mode)
    else $error("accepted offset not stored or ramp not started");
  a_busy_reject: assert property (
    cmd_valid_in && busy |=> cmd_reject_out && !cmd_ack_out)
    else $error("command taken during ramp");
  a_mask_restart: assert property (
    step_now |=> mask_q ##1 ready_mask_out)
    else $error("masking timer not restarted by code change");
  a_ramp_full_power: assert property (
    busy && !start_up |-> ps == FULL_POWER_STATE)
    else $error("ramp without full power state");
  a_ramp_active_min: assert property (
    $fell(ramp_active_out) && enable_in |-> $past(ra_cnt) >= 5'(RAMP_MIN_CYC))
    else $error("ramp active shorter than least hold");
  a_decay_ps_defer: assert property (
    cmd_valid_in && state == ST_DECAY && cmd_code_in == CMD_SET_POWER_STATE &&
      !at_dest && enable_in |=> $stable(ps) && ps_pending)
    else $error("power command applied during decay");
  a_hold_at_dest: assert property (
    state == ST_IDLE && !cmd_valid_in && !start_up && enable_in |=> $stable(code))
    else $error("code moved while idle");
  a_shutdown_clear: assert property (
    !enable_in |=> !ramp_active_out && state == ST_IDLE && code == CODE_RST ##1 !mask_q)
    else $error("shutdown did not clear sequencer");

endmodule

/* vtrs_pkg.sv */
// Shared constants and types for the voltage target ramp sequencer
package vtrs_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Voltage code
  localparam int          CODE_W    = 8;
  localparam logic [7:0]  CODE_MAX  = 8'hff;
  localparam int          STEP_MV   = 10;
  localparam int          TOP_MV    = 3040;
  localparam logic [7:0]  CODE_RST  = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ       = 100;
  localparam int RAMP_CLK_MHZ  = 4;
  localparam int RAMP_DIV      = CLK_MHZ / RAMP_CLK_MHZ;
  localparam int RAMP_MIN_NS   = 250;
  localparam int RAMP_MIN_CYC  = (RAMP_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int MASK_TIME_NS  = 2000;
  localparam int MASK_CYC      = (MASK_TIME_NS * CLK_MHZ + 999) / 1000;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  localparam logic [7:0] REG_SLOW_RATE = 8'h25;
  localparam logic [7:0] REG_OFFSET    = 8'h33;
  localparam logic [7:0] SLOW_RATE_RST = 8'h04;
  localparam logic [7:0] OFFSET_RST    = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Power states
  localparam logic [1:0] FULL_POWER_STATE = 2'h0;
  localparam logic [1:0] DECAY_PS         = 2'h2;
  localparam logic [1:0] DEEP_PS          = 2'h3;

  typedef enum logic [2:0] {
    CMD_SET_TARGET_FAST  = 3'h0,
    CMD_SET_TARGET_SLOW  = 3'h1,
    CMD_SET_TARGET_DECAY = 3'h2,
    CMD_SET_POWER_STATE  = 3'h3,
    CMD_SET_REG          = 3'h4,
    CMD_GET_REG          = 3'h5
  } cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_RAMP  = 2'b01,
    ST_DECAY = 2'b10
  } seq_state_t;

endpackage

/* ramp_tick_gen.sv */
// Divider giving one-cycle ramp clock enable pulses
module ramp_tick_gen #(
  parameter int DIV = 25
) (
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_in,
  // Control
  input  wire logic run_in,
  output logic      tick_out
);
  localparam int CW = $clog2(DIV);
  logic [CW-1:0] cnt;

  if (DIV < 2) begin : g_div_check
    $error("ramp_tick_gen: DIV must be at least 2");
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in || !run_in) begin
      cnt      <= '0;
      tick_out <= 1'b0;
    end else if (cnt == CW'(DIV - 1)) begin
      cnt      <= '0;
      tick_out <= 1'b1;
    end else begin
      cnt      <= cnt + CW'(1);
      tick_out <= 1'b0;
    end
  end
endmodule

/* ready_mask_timer.sv */
// Retriggerable timer masking the ready indication after a code change
module ready_mask_timer #(
  parameter int CYC = 200
) (
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic rst_in,
  // Control
  input  wire logic stop_in,
  input  wire logic restart_in,
  output logic      mask_out
);
  localparam int CW = $clog2(CYC + 1);
  logic [CW-1:0] cnt;

  if (CYC < 1) begin : g_cyc_check
    $error("ready_mask_timer: CYC must be at least 1");
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in || stop_in) begin
      cnt      <= '0;
      mask_out <= 1'b0;
    end else if (restart_in) begin
      cnt      <= CW'(CYC);
      mask_out <= 1'b1;
    end else if (cnt != '0) begin
      cnt      <= cnt - CW'(1);
      mask_out <= (cnt != CW'(1));
    end
  end
endmodule

/* vtrs_host.sv */
// Bus master model that issues voltage control commands and settle pulses
module vtrs_host
  import vtrs_pkg::*;
(
  // Clock
  input  wire logic           mclk_in,
  // Answer from the sequencer
  input  wire logic           ack_in,
  input  wire logic           reject_in,
  // Command strobe and payload
  output logic                valid_out,
  output vtrs_pkg::cmd_t      code_out,
  output logic [7:0]          addr_out,
  output logic [7:0]          data_out,
  // Settle feedback
  output logic                settled_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    valid_out = 1'b0;
    code_out = CMD_GET_REG;
    addr_out = 8'h00;
    data_out = 8'h00;
    settled_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Payload is held until the taking edge, then address and data are left garbled on release
  task automatic send(input cmd_t c, input logic [7:0] a, input logic [7:0] d,
                      output logic [1:0] r);
    @(posedge mclk_in);
    #1;
    valid_out = 1'b1;
    code_out = c;
    addr_out = a;
    data_out = d;
    @(posedge mclk_in);
    #1;
    r = {ack_in, reject_in};
    valid_out = 1'b0;
    addr_out = ~a;
    data_out = ~d;
  endtask

  // One settle assertion, then time for the step to land
  task automatic settle;
    @(posedge mclk_in);
    #1;
    settled_out = 1'b1;
    @(posedge mclk_in);
    #1;
    settled_out = 1'b0;
    repeat (4) @(posedge mclk_in);
    #1;
  endtask
endmodule

/* voltage_target_ramp_sequencer_test.sv */
// Self-checking bench for the voltage target ramp sequencer
module voltage_target_ramp_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import vtrs_pkg::*;

  localparam int         DIV  = 2;
  localparam int         MCYC = 4;
  localparam logic [1:0] ACK  = 2'b10;
  localparam logic [1:0] REJ  = 2'b01;

  logic       mclk, rst, enable, settled, valid, ack, rej, ramp, mask, phases, mon_on;
  logic [7:0] boot, addr, data, rsp, code, last_code;
  logic [1:0] ps;
  cmd_t       ccode;
  int         num_errors, total_checks, gap, last_gap;

  always #5 mclk = ~mclk;

  voltage_target_ramp_sequencer #(.RAMP_DIV_P(DIV), .MASK_CYC_P(MCYC)) i_dut (
    .mclk_in(mclk), .rst_in(rst), .enable_in(enable), .boot_code_in(boot),
    .cmd_valid_in(valid), .cmd_code_in(ccode), .cmd_addr_in(addr),
    .cmd_data_in(data), .cmd_ack_out(ack), .cmd_reject_out(rej),
    .rsp_data_out(rsp), .settled_flag_in(settled), .voltage_code_out(code),
    .ramp_active_out(ramp), .ready_mask_out(mask), .power_state_out(ps),
    .all_phases_out(phases));

  vtrs_host i_host (
    .mclk_in(mclk), .ack_in(ack), .reject_in(rej), .valid_out(valid),
    .code_out(ccode), .addr_out(addr), .data_out(data), .settled_out(settled));

  ////////////////////////////////////////////////////////////////////////////
  // Compare, wait and command helpers
  task automatic check8(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic check1(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic issue(input cmd_t c, input logic [7:0] a, input logic [7:0] d,
                       input logic [1:0] e);
    logic [1:0] r;
    i_host.send(c, a, d, r);
    check8("command outcome", {6'h00, e}, {6'h00, r});
  endtask

  task automatic wait_code(input logic [7:0] t, input int lim);
    int i;
    i = 0;
    while (code !== t && i < lim) begin
      step(1);
      i++;
    end
    check8("voltage code", t, code);
  endtask

  // Every code change is one step, never closer than one ramp tick
  always @(posedge mclk) begin
    gap <= gap + 1;
    last_code <= code;
    if (mon_on && code !== last_code) begin
      check8("step size", 8'h01, (code > last_code) ? code - last_code : last_code - code);
      check1("step spacing", 1'b1, gap >= DIV);
      last_gap <= gap;
      gap <= 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    step(15);
    check8("code in reset", 8'h00, code);
    check1("ramp in reset", 1'b0, ramp);
    check1("mask in reset", 1'b0, mask);
    check1("phases in reset", 1'b1, phases);
    step(1);
    rst = 1'b0;
    mon_on = 1'b1;
    step(1);
    enable = 1'b1;
    issue(CMD_SET_TARGET_FAST, 8'h00, 8'h20, REJ);
    wait_code(8'h03, 200);
    step(40);
  endtask

  task automatic t_regs;
    issue(CMD_GET_REG, REG_SLOW_RATE, 8'h00, ACK);
    check8("slow rate reset", SLOW_RATE_RST, rsp);
    issue(CMD_GET_REG, REG_OFFSET, 8'h00, ACK);
    check8("offset reset", OFFSET_RST, rsp);
    issue(CMD_SET_REG, 8'h40, 8'h11, REJ);
    issue(CMD_GET_REG, 8'h40, 8'h00, ACK);
    check8("unmapped read", 8'h00, rsp);
    issue(CMD_SET_REG, REG_SLOW_RATE, 8'h02, ACK);
    issue(CMD_GET_REG, REG_SLOW_RATE, 8'h00, ACK);
    check8("slow rate", 8'h02, rsp);
  endtask

  task automatic t_fast;
    int i;
    issue(CMD_SET_TARGET_FAST, 8'h00, 8'h08, ACK);
    check1("ramp active", 1'b1, ramp);
    check1("all phases", 1'b1, phases);
    check8("power state", {6'h00, FULL_POWER_STATE}, {6'h00, ps});
    issue(CMD_SET_TARGET_SLOW, 8'h00, 8'h01, REJ);
    wait_code(8'h08, 100);
    step(1);
    check8("fast spacing", 8'(DIV), 8'(last_gap));
    check1("mask after step", 1'b1, mask);
    step(30);
    check1("mask expired", 1'b0, mask);
    check1("ramp done", 1'b0, ramp);
    check8("code holds", 8'h08, code);
    issue(CMD_SET_TARGET_FAST, 8'h00, 8'h09, ACK);
    i = 0;
    while (ramp === 1'b1 && i < 100) begin
      step(1);
      i++;
    end
    check1("ramp minimum", 1'b1, i >= RAMP_MIN_CYC);
    check8("one step", 8'h09, code);
    step(20);
  endtask

  task automatic t_slow;
    issue(CMD_SET_TARGET_SLOW, 8'h00, 8'h04, ACK);
    wait_code(8'h04, 200);
    step(1);
    check8("slow spacing", 8'(2 * DIV), 8'(last_gap));
    step(30);
  endtask

  task automatic t_offset;
    issue(CMD_SET_REG, REG_OFFSET, 8'hfc, REJ);
    issue(CMD_SET_REG, REG_OFFSET, 8'hfb, ACK);
    issue(CMD_GET_REG, REG_OFFSET, 8'h00, REJ);
    wait_code(8'hff, 2500);
    step(1);
    check8("offset spacing", 8'(2 * DIV), 8'(last_gap));
    step(30);
    issue(CMD_GET_REG, REG_OFFSET, 8'h00, ACK);
    check8("offset stored", 8'hfb, rsp);
    issue(CMD_SET_REG, REG_OFFSET, 8'h00, ACK);
    wait_code(8'h04, 2500);
    step(30);
  endtask

  task automatic t_power;
    issue(CMD_SET_POWER_STATE, 8'h00, 8'h03, ACK);
    step(1);
    check8("deep state", 8'h03, {6'h00, ps});
    issue(CMD_SET_TARGET_FAST, 8'h00, 8'h06, ACK);
    step(1);
    check8("leave low power", 8'h00, {6'h00, ps});
    check1("phases forced", 1'b1, phases);
    wait_code(8'h06, 100);
    step(30);
    check8("stays full power", 8'h00, {6'h00, ps});
    issue(CMD_SET_TARGET_DECAY, 8'h00, 8'h03, ACK);
    step(1);
    check8("decay state", {6'h00, DECAY_PS}, {6'h00, ps});
    issue(CMD_SET_POWER_STATE, 8'h00, 8'h01, ACK);
    i_host.settle();
    check8("one decay step", 8'h05, code);
    check8("state deferred", {6'h00, DECAY_PS}, {6'h00, ps});
    i_host.settle();
    i_host.settle();
    check8("decay target", 8'h03, code);
    step(3);
    check8("deferred applied", 8'h01, {6'h00, ps});
    issue(CMD_SET_POWER_STATE, 8'h00, 8'h03, ACK);
    issue(CMD_SET_TARGET_DECAY, 8'h00, 8'h01, ACK);
    step(1);
    check8("deep state kept", {6'h00, DEEP_PS}, {6'h00, ps});
    i_host.settle();
    check8("decay part way", 8'h02, code);
    issue(CMD_SET_TARGET_FAST, 8'h00, 8'h05, ACK);
    step(1);
    check8("decay ended", 8'h00, {6'h00, ps});
    wait_code(8'h05, 100);
    step(30);
  endtask

  task automatic t_shutdown;
    issue(CMD_SET_TARGET_FAST, 8'h00, 8'h0a, ACK);
    step(4);
    mon_on = 1'b0;
    enable = 1'b0;
    step(2);
    check1("ramp cleared", 1'b0, ramp);
    check1("mask cleared", 1'b0, mask);
    check8("code cleared", 8'h00, code);
    issue(CMD_SET_TARGET_FAST, 8'h00, 8'h02, REJ);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, main sequence and watchdog
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    rst = 1'b1;
    enable = 1'b0;
    boot = 8'h03;
    mon_on = 1'b0;
    num_errors = 0;
    total_checks = 0;
    gap = 0;
    last_gap = 0;
    last_code = 8'h00;
    t_reset;
    t_regs;
    t_fast;
    t_slow;
    t_offset;
    t_power;
    t_shutdown;
    complete_run;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    complete_run;
  end
endmodule
